// ===== adc_conversion_sequencer.sv
// Conversion sequencer: register file, phase timing, averaging, chopping and storage
`timescale 1ns/100ps
`include "adc_seq_defs.svh"
module adc_conversion_sequencer
  import adc_seq_pkg::*;
#(
  parameter int unsigned STEP_CYCLES = `SAMPLE_CYCLES_PER_STEP,
  parameter int unsigned SYNC_CYCLES = `HANDSHAKE_SYNC_CYCLES
)
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [15:0] reg_rdata,
  output logic core_sample,
  output logic core_start,
  output logic core_sign,
  output logic core_mute,
  output logic core_single_ended,
  output logic [1:0] core_attn,
  output logic core_dummy_load,
  output logic [9:0] core_trim_pos,
  output logic [9:0] core_trim_neg,
  input wire logic core_ready,
  input wire logic [9:0] core_data
);
  // The sample counter is eight bits wide, so fifteen steps must fit below 256
  if (STEP_CYCLES == 0 || STEP_CYCLES > 17)
  begin : g_step_check
    $error("sample step count out of range");
  end
  // The handshake synchroniser is built two flip-flops deep
  if (SYNC_CYCLES != 2)
  begin : g_sync_check
    $error("only a two-stage synchroniser is provided");
  end

  typedef struct packed {
    seq_state_t st;
    logic start_busy;
    logic cont;
    logic chop;
    logic mute;
    logic sign;
    logic single_ended;
    logic done_flag;
    logic [3:0] smpl_time;
    logic [3:0] store_del;
    logic [2:0] nrs;
    attn_t attn;
    logic dummy;
    logic [9:0] trim_p;
    logic [9:0] trim_n;
    logic [15:0] result;
    logic [9:0] last_sample;
    logic [7:0] count;
    logic [8:0] conv_left;
    logic conv_sign;
    logic got_data;
    logic ready_s1;
    logic ready_s2;
    logic ready_s3;
    logic [9:0] data_s1;
    logic [9:0] data_s2;
    logic [15:0] rdata;
    logic sample_out;
    logic start_out;
  } seq_t;

  seq_t state;
  seq_t next_state;
  logic ready_rise;
  adc_seq_acc_if acc_link ();

  // A fresh rising edge is needed: the core leaves ready high from the previous conversion
  assign ready_rise = state.ready_s2 && !state.ready_s3;

  adc_seq_acc acc_inst (
    .clock(clock),
    .rst_n(rst_n),
    .bus(acc_link.acc)
  );

  function automatic logic hit(input logic [3:0] addr, input logic [3:0] ofs);
    hit = (addr == ofs);
  endfunction

  // Chop forces at least two conversions even with exponent zero
  function automatic logic [8:0] conv_total(input logic [2:0] n, input logic chop_on);
    logic [8:0] t;
    t = 9'h001 << n;
    if (chop_on && n == 3'h0)
      t = 9'h002;
    conv_total = t;
  endfunction

  function automatic logic [2:0] div_shift(input logic [2:0] n, input logic chop_on);
    div_shift = (chop_on && n == 3'h0) ? 3'h1 : n;
  endfunction

  // Primary control write, used only by the relaunch decision in the finish state
  function automatic logic primary_write(input logic wr, input logic [3:0] addr);
    primary_write = wr && hit(addr, `OFS_PRIMARY_CONTROL);
  endfunction

  always_comb
  begin
    next_state = state;
    acc_link.clear = 1'b0;
    acc_link.add = 1'b0;
    acc_link.sample = state.data_s2;
    acc_link.shift = div_shift(state.nrs, state.chop);
    // Two-stage synchronisers for the core's handshake and data
    next_state.ready_s1 = core_ready;
    next_state.ready_s2 = state.ready_s1;
    next_state.ready_s3 = state.ready_s2;
    next_state.data_s1 = core_data;
    next_state.data_s2 = state.data_s1;
    next_state.sample_out = 1'b0;
    next_state.start_out = 1'b0;
    next_state.rdata = 16'h0000;

    // Register reads, no side effects
    if (reg_read)
    begin
      if (hit(reg_addr, `OFS_PRIMARY_CONTROL))
        next_state.rdata = {9'h000, state.done_flag, state.single_ended, state.sign,
          state.mute, state.chop, state.cont, state.start_busy};
      else if (hit(reg_addr, `OFS_SECONDARY_CONTROL))
        next_state.rdata = {2'h0, state.dummy, state.attn, state.nrs, state.store_del,
          state.smpl_time};
      else if (hit(reg_addr, `OFS_CONVERSION_RESULT))
        next_state.rdata = state.result;
      else if (hit(reg_addr, `OFS_POSITIVE_OFFSET_TRIM))
        next_state.rdata = {6'h00, state.trim_p};
      else if (hit(reg_addr, `OFS_NEGATIVE_OFFSET_TRIM))
        next_state.rdata = {6'h00, state.trim_n};
      else
        next_state.rdata = 16'h0000;
    end

    // Register writes; a done set in the finish state below wins over a clear
    if (reg_write)
    begin
      if (hit(reg_addr, `OFS_PRIMARY_CONTROL))
      begin
        next_state.cont = reg_wdata[`PC_CONT_BIT];
        next_state.chop = reg_wdata[`PC_CHOP_BIT];
        next_state.mute = reg_wdata[`PC_MUTE_BIT];
        next_state.sign = reg_wdata[`PC_SIGN_BIT];
        next_state.single_ended = reg_wdata[`PC_SE_BIT];
        // A start while busy is ignored
        if (reg_wdata[`PC_START_BIT] && !state.start_busy)
          next_state.start_busy = 1'b1;
      end
      else if (hit(reg_addr, `OFS_SECONDARY_CONTROL))
      begin
        next_state.smpl_time = reg_wdata[`SC_SMPL_LSB +: 4];
        next_state.store_del = reg_wdata[`SC_STORE_LSB +: 4];
        next_state.nrs = reg_wdata[`SC_NRS_LSB +: 3];
        next_state.attn = attn_t'(reg_wdata[`SC_ATTN_LSB +: 2]);
        next_state.dummy = reg_wdata[`SC_I20U_BIT];
      end
      else if (hit(reg_addr, `OFS_POSITIVE_OFFSET_TRIM))
        next_state.trim_p = reg_wdata[9:0];
      else if (hit(reg_addr, `OFS_NEGATIVE_OFFSET_TRIM))
        next_state.trim_n = reg_wdata[9:0];
      else if (hit(reg_addr, `OFS_CLEAR_DONE))
        next_state.done_flag = 1'b0;
    end

    case (state.st)
      st_idle:
      begin
        // Launch reloads the count so a new exponent or chop setting takes effect
        if (state.start_busy)
        begin
          acc_link.clear = 1'b1;
          next_state.conv_left = conv_total(state.nrs, state.chop);
          next_state.conv_sign = state.sign;
          next_state.count = 8'h00;
          next_state.st = st_sample;
        end
      end
      st_sample:
      begin
        next_state.sample_out = 1'b1;
        next_state.count = state.count + 8'h01;
        // Zero sample time still gives the two-cycle minimum
        if (state.count + 8'h01 >=
          ((state.smpl_time == 4'h0) ? 8'h02 : state.smpl_time * STEP_CYCLES[7:0]))
        begin
          next_state.count = 8'h00;
          next_state.got_data = 1'b0;
          next_state.start_out = 1'b1;
          next_state.st = st_convert;
        end
      end
      st_convert:
      begin
        next_state.count = state.count + 8'h01;
        if (ready_rise)
          next_state.got_data = 1'b1;
        if (state.store_del == 4'h0)
        begin
          // Handshake: wait for a fresh synchronised ready after two convert cycles
          if ((ready_rise || state.got_data) && state.count >= 8'h01)
            next_state.st = st_store;
        end
        else if (state.count >= {4'h0, state.store_del})
          next_state.st = st_store;
      end
      st_store:
      begin
        acc_link.add = 1'b1;
        // Stale data reused when fixed delay ran out before the core finished
        if (!state.got_data && state.store_del != 4'h0)
          acc_link.sample = state.last_sample;
        else
          next_state.last_sample = state.data_s2;
        next_state.conv_left = state.conv_left - 9'h001;
        if (state.chop)
          next_state.conv_sign = ~state.conv_sign;
        next_state.count = 8'h00;
        if (state.conv_left == 9'h001)
          next_state.st = st_finish;
        else
          next_state.st = st_sample;
      end
      st_finish:
      begin
        next_state.result = acc_link.result;
        next_state.done_flag = 1'b1;
        // A write clearing the continuous bit in this very cycle stops the relaunch
        if (state.cont && !(primary_write(reg_write, reg_addr) && !reg_wdata[`PC_CONT_BIT]))
        begin
          acc_link.clear = 1'b1;
          next_state.conv_left = conv_total(state.nrs, state.chop);
          next_state.conv_sign = state.sign;
          next_state.st = st_sample;
        end
        else
        begin
          next_state.start_busy = 1'b0;
          next_state.st = st_idle;
        end
      end
      default:
        next_state.st = st_idle;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= '0;
      state.st <= st_idle;
      state.attn <= attn_bypass;
      // Trims leave reset at neutral mid-scale
      state.trim_p <= `TRIM_RESET;
      state.trim_n <= `TRIM_RESET;
    end
    else
      state <= next_state;
  end

  assign reg_rdata = state.rdata;
  assign core_sample = state.sample_out;
  assign core_start = state.start_out;
  assign core_sign = state.conv_sign;
  assign core_mute = state.mute;
  assign core_single_ended = state.single_ended;
  assign core_attn = state.attn;
  assign core_dummy_load = state.dummy;
  assign core_trim_pos = state.trim_p;
  assign core_trim_neg = state.trim_n;
endmodule // adc_conversion_sequencer

// ===== adc_seq_acc.sv
// Sample accumulator that averages 2^N samples into a 16-bit left-aligned result
`timescale 1ns/100ps
module adc_seq_acc
  import adc_seq_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  adc_seq_acc_if.acc bus
);
  typedef struct packed {
    logic [17:0] sum;
  } acc_state_t;
  acc_state_t state;
  acc_state_t next_state;
  logic [23:0] scaled;
  always_comb
  begin
    next_state = state;
    if (bus.clear)
      next_state.sum = 18'h0_0000;
    else if (bus.add)
      next_state.sum = state.sum + {8'h00, bus.sample};
  end
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      state <= '0;
    else
      state <= next_state;
  end
  // Left align then divide; fractional bits kept below the 10-bit width
  always_comb
  begin
    scaled = {state.sum, 6'h00} >> bus.shift;
  end
  assign bus.result = scaled[15:0];
endmodule // adc_seq_acc

// ===== adc_seq_acc_if.sv
// Link between the sequencer and its accumulator
`timescale 1ns/100ps
interface adc_seq_acc_if;
  logic clear;
  logic add;
  logic [9:0] sample;
  logic [2:0] shift;
  logic [15:0] result;
  modport seq (output clear, output add, output sample, output shift, input result);
  modport acc (input clear, input add, input sample, input shift, output result);
endinterface

// ===== adc_seq_defs.svh
// Register offsets, field positions, reset values and timing counts of the conversion sequencer
`ifndef ADC_SEQ_DEFS_SVH
`define ADC_SEQ_DEFS_SVH
`define OFS_PRIMARY_CONTROL 4'h0
`define OFS_SECONDARY_CONTROL 4'h1
`define OFS_CONVERSION_RESULT 4'h2
`define OFS_POSITIVE_OFFSET_TRIM 4'h3
`define OFS_NEGATIVE_OFFSET_TRIM 4'h4
`define OFS_CLEAR_DONE 4'h5
`define PC_START_BIT 0
`define PC_CONT_BIT 1
`define PC_CHOP_BIT 2
`define PC_MUTE_BIT 3
`define PC_SIGN_BIT 4
`define PC_SE_BIT 5
`define PC_DONE_BIT 6
`define SC_SMPL_LSB 0
`define SC_STORE_LSB 4
`define SC_NRS_LSB 8
`define SC_ATTN_LSB 11
`define SC_I20U_BIT 13
`define TRIM_RESET 10'h200
`define SAMPLE_CYCLES_PER_STEP 8
`define HANDSHAKE_SYNC_CYCLES 2
`endif

// ===== adc_seq_pkg.sv
// Types shared by the conversion sequencer and its accumulator
package adc_seq_pkg;
  typedef enum logic [2:0] {st_idle, st_sample, st_convert, st_store, st_finish} seq_state_t;
  typedef enum logic [1:0] {attn_bypass, attn_div2, attn_div3, attn_div4} attn_t;
endpackage

// ===== adc_seq_properties.sv
// Port-level timing checks for the conversion sequencer
`timescale 1ns/100ps
`include "adc_seq_defs.svh"
module adc_seq_properties
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [15:0] reg_rdata,
  input wire logic core_sample,
  input wire logic core_start,
  input wire logic core_sign,
  input wire logic core_mute,
  input wire logic [1:0] core_attn,
  input wire logic core_dummy_load,
  input wire logic [9:0] core_trim_pos,
  input wire logic [9:0] core_trim_neg
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_rdata_idle_zero: assert property (!reg_read |=> reg_rdata == 16'h0000)
    else $error("read data not zero outside read answer");
  a_start_one_cycle: assert property (core_start |=> !core_start)
    else $error("core start longer than one cycle");
  a_sample_min_len: assert property ($rose(core_sample) |-> core_sample [*2])
    else $error("sampling phase shorter than two cycles");
  a_sign_hold: assert property (core_sample && $past(core_sample) |-> $stable(core_sign))
    else $error("offset sign changed while sampling");
  a_trim_pos_load: assert property (reg_write && reg_addr == `OFS_POSITIVE_OFFSET_TRIM
    |=> core_trim_pos == $past(reg_wdata[9:0]))
    else $error("positive trim not loaded");
  a_trim_neg_load: assert property (reg_write && reg_addr == `OFS_NEGATIVE_OFFSET_TRIM
    |=> core_trim_neg == $past(reg_wdata[9:0]))
    else $error("negative trim not loaded");
  a_attn_load: assert property (reg_write && reg_addr == `OFS_SECONDARY_CONTROL
    |=> core_attn == $past(reg_wdata[12:11]) && core_dummy_load == $past(reg_wdata[13]))
    else $error("attenuation or dummy load not loaded");
  a_mute_load: assert property (reg_write && reg_addr == `OFS_PRIMARY_CONTROL
    |=> core_mute == $past(reg_wdata[`PC_MUTE_BIT]))
    else $error("mute not loaded");
endmodule // adc_seq_properties

// ===== tb.sv
// Self-checking bench for the conversion sequencer
`timescale 1ns/100ps
`include "adc_seq_defs.svh"
module tb;
  import adc_seq_pkg::*;
  logic clock = 0, rst_n = 0, reg_write = 0, reg_read = 0, core_ready = 0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000, rdv, reg_rdata;
  logic [9:0] core_data = 10'h000, base = 10'h064, core_trim_pos, core_trim_neg;
  logic [9:0] cm_trim = 10'h200, tdev;
  logic [1:0] core_attn;
  logic core_sample, core_start, core_sign, core_mute, core_single_ended, core_dummy_load;
  int mismatches = 0, tests_run = 0, cycles = 0, lat = 3, cnt = 0, starts = 0, neg = 0;
  always #2 clock = ~clock;
  adc_conversion_sequencer i_adc_conversion_sequencer (
    .clock(clock),
    .rst_n(rst_n),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_write(reg_write),
    .reg_read(reg_read),
    .reg_rdata(reg_rdata),
    .core_sample(core_sample),
    .core_start(core_start),
    .core_sign(core_sign),
    .core_mute(core_mute),
    .core_single_ended(core_single_ended),
    .core_attn(core_attn),
    .core_dummy_load(core_dummy_load),
    .core_trim_pos(core_trim_pos),
    .core_trim_neg(core_trim_neg),
    .core_ready(core_ready),
    .core_data(core_data)
  );
  // Trim away from the chosen common mode moves the stand-in's result; half as much single ended
  assign tdev = (core_sign ? core_trim_neg : core_trim_pos) - cm_trim;
  // Core stand-in: ready after lat cycles, data scrambled while sampling
  always @(posedge clock)
  begin
    if (core_start)
    begin
      starts <= starts + 1;
      neg <= neg + int'(core_sign);
      cnt <= lat;
    end
    else if (cnt > 0)
      cnt <= cnt - 1;
    if (cnt == 1 && !core_start)
    begin
      core_ready <= 1'b1;
      core_data <= (core_mute ? 10'h200 : base) + (core_sign ? 10'h3fd : 10'h003)
        + (core_single_ended ? {tdev[9], tdev[9:1]} : tdev);
    end
    if (core_sample)
    begin
      core_ready <= 1'b0;
      core_data <= ~core_data;
    end
    // Ceiling well above the longest expected run of some four thousand cycles
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      give_verdict;
    end
  end
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    tests_run++;
    if (g !== e)
    begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic rc(input logic [3:0] a, input logic [15:0] e);
    rd(a, rdv);
    chk(rdv, e);
  endtask
  task automatic idle;
    for (int i = 0; i < 2000; i++)
    begin
      rd(`OFS_PRIMARY_CONTROL, rdv);
      if (rdv[0] === 1'b0)
        break;
    end
  endtask
  // One conversion: checks done flag, result, conversion count and negative-sign count
  task automatic conv(input logic [15:0] c, s, e, input int n, nn);
    wr(`OFS_SECONDARY_CONTROL, s);
    starts = 0;
    neg = 0;
    wr(`OFS_PRIMARY_CONTROL, c | 16'h0001);
    idle;
    chk(rdv & 16'h0041, 16'h0040);
    rc(`OFS_CONVERSION_RESULT, e);
    rc(`OFS_CONVERSION_RESULT, e);
    chk(16'(starts), 16'(n));
    chk(16'(neg), 16'(nn));
    wr(`OFS_CLEAR_DONE, 16'h0000);
    rd(`OFS_PRIMARY_CONTROL, rdv);
    chk(rdv & 16'h0040, 16'h0000);
  endtask
  // Calibration as software runs it: two signed deviations at mid-scale, new trims, a check
  task automatic calib(input logic [15:0] se, input logic [9:0] cm);
    logic [9:0] dp, dn;
    cm_trim = cm;
    wr(`OFS_POSITIVE_OFFSET_TRIM, {6'h00, cm});
    wr(`OFS_NEGATIVE_OFFSET_TRIM, {6'h00, cm});
    conv(se | 16'h0008, 16'h0302, {10'h203, 6'h00}, 8, 0);
    rd(`OFS_CONVERSION_RESULT, rdv);
    dp = rdv[15:6] - 10'h200;
    conv(se | 16'h0018, 16'h0302, {10'h1fd, 6'h00}, 8, 8);
    rd(`OFS_CONVERSION_RESULT, rdv);
    dn = rdv[15:6] - 10'h200;
    wr(`OFS_POSITIVE_OFFSET_TRIM, {6'h00, cm - (se[5] ? {dp[8:0], 1'b0} : dp)});
    wr(`OFS_NEGATIVE_OFFSET_TRIM, {6'h00, cm - (se[5] ? {dn[8:0], 1'b0} : dn)});
    conv(se | 16'h0008, 16'h0302, {10'h200, 6'h00}, 8, 0);
    conv(se | 16'h0018, 16'h0302, {10'h200, 6'h00}, 8, 8);
  endtask
  task automatic give_verdict;
    $display("mismatches %0d tests_run %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    rc(`OFS_POSITIVE_OFFSET_TRIM, 16'h0200);
    rc(`OFS_NEGATIVE_OFFSET_TRIM, 16'h0200);
    rc(4'hf, 16'h0000);
    wr(`OFS_POSITIVE_OFFSET_TRIM, 16'h0123);
    chk(16'(core_trim_pos), 16'h0123);
    wr(`OFS_POSITIVE_OFFSET_TRIM, 16'h0200);
    for (int i = 0; i < 4; i++)
    begin
      wr(`OFS_SECONDARY_CONTROL, (16'(i) << `SC_ATTN_LSB) | 16'h2000);
      chk(16'(core_attn), 16'(i));
      chk(16'(core_dummy_load), 16'h0001);
    end
    wr(`OFS_PRIMARY_CONTROL, 16'h0028);
    chk(16'({core_mute, core_single_ended}), 16'h0003);
    conv(16'h0000, 16'h0000, {base + 10'h003, 6'h00}, 1, 0);
    conv(16'h0010, 16'h0200, {base - 10'h003, 6'h00}, 4, 4);
    conv(16'h0004, 16'h0000, {base, 6'h00}, 2, 1);
    conv(16'h0004, 16'h0200, {base, 6'h00}, 4, 2);
    conv(16'h0000, 16'h0701, {base + 10'h003, 6'h00}, 128, 0);
    // Core too slow for the store delay: the old sample is kept
    base = 10'h0c8;
    lat = 30;
    conv(16'h0000, 16'h0010, {10'h067, 6'h00}, 1, 0);
    lat = 3;
    conv(16'h0000, 16'h00f0, {base + 10'h003, 6'h00}, 1, 0);
    calib(16'h0020, 10'h200);
    calib(16'h0000, 10'h300);
    wr(`OFS_SECONDARY_CONTROL, 16'h0000);
    starts = 0;
    wr(`OFS_PRIMARY_CONTROL, 16'h0003);
    for (int i = 0; i < 500 && starts < 3; i++)
      @(posedge clock);
    wr(`OFS_PRIMARY_CONTROL, 16'h0000);
    idle;
    chk(16'(starts > 2), 16'h0001);
    give_verdict;
  end
endmodule // tb
bind adc_conversion_sequencer adc_seq_properties i_adc_seq_properties (
  .clock(clock),
  .rst_n(rst_n),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_write(reg_write),
  .reg_read(reg_read),
  .reg_rdata(reg_rdata),
  .core_sample(core_sample),
  .core_start(core_start),
  .core_sign(core_sign),
  .core_mute(core_mute),
  .core_attn(core_attn),
  .core_dummy_load(core_dummy_load),
  .core_trim_pos(core_trim_pos),
  .core_trim_neg(core_trim_neg)
);
